//--- sprb_pkg.sv
// Package of register offsets, field positions and reset values for the bank
package sprb_pkg;

    // ****************************************************************
    // Register map, APB byte addresses, two words per 64-bit register
    // ****************************************************************
    localparam logic [7:0] SPRB_ASR_LO = 8'h00;
    localparam logic [7:0] SPRB_ASR_HI = 8'h04;
    localparam logic [7:0] SPRB_DFA_LO = 8'h08;
    localparam logic [7:0] SPRB_DFA_HI = 8'h0c;
    localparam logic [7:0] SPRB_SCR_BASE = 8'h10;
    localparam logic [7:0] SPRB_SFC = 8'h30;
    localparam logic [7:0] SPRB_CTRL = 8'h34;
    localparam logic [7:0] SPRB_STAT = 8'h38;

    // ****************************************************************
    // Field positions, bit 0 is the most significant bit of a register
    // ****************************************************************
    localparam int SPRB_STO_MSB = 0;
    localparam int SPRB_STO_LSB = 51;
    localparam int SPRB_VALID_BIT = 63;
    localparam int SPRB_NUM_SCR = 4;
    localparam int SPRB_SEG_ENTRIES = 16;

    // Big-endian bit numbers map to little-endian vector indices
    localparam int SPRB_V_IDX = 63 - SPRB_VALID_BIT;
    localparam logic [63:0] SPRB_ASR_MASK = 64'hffff_ffff_ffff_f000;
    localparam logic [63:0] SPRB_LO32_MASK = 64'h0000_0000_ffff_ffff;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [63:0] SPRB_RST64 = 64'h0;
    localparam logic [31:0] SPRB_RST32 = 32'h0;
    localparam logic [31:0] SPRB_SFC_IMPL = 32'hffff_ffff;
    localparam logic [31:0] SPRB_ERR_DATA = 32'h0;

    typedef enum logic [1:0]
    {
        SPRB_IDLE = 2'b00,
        SPRB_ACC = 2'b01
    } sprb_apb_t;

endpackage

//--- sprb_trap_if.sv
// Interface carrying exception loads from the core into the bank
`timescale 1ns/1ps
interface sprb_trap_if;
    logic dfa_load;
    logic [63:0] dfa_ea;
    logic mode32;
    logic sfc_load;
    logic [31:0] sfc_val;
    modport core (output dfa_load, dfa_ea, mode32, sfc_load, sfc_val);
    modport bank (input dfa_load, dfa_ea, mode32, sfc_load, sfc_val);
endinterface

//--- sprb_fault_capture.sv
// Fault address and cause capture registers loaded on exceptions
`timescale 1ns/1ps
module sprb_fault_capture
    import sprb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sprb_trap_if.bank trap,
    input wire logic [31:0] sfc_impl_mask,
    input wire logic [1:0] sw_dfa_we,
    input wire logic sw_sfc_we,
    input wire logic [31:0] sw_wdata,
    output logic [63:0] dfa_ff,
    output logic [31:0] sfc_ff
);
    logic [63:0] nxt_dfa;
    logic [31:0] nxt_sfc;

    always_comb
    begin
        nxt_dfa = dfa_ff;
        if (sw_dfa_we[0])
            nxt_dfa[31:0] = sw_wdata;
        if (sw_dfa_we[1])
            nxt_dfa[63:32] = sw_wdata;
        // Hardware capture takes priority over a software write
        if (trap.dfa_load)
        begin
            nxt_dfa = trap.dfa_ea;
            if (trap.mode32)
                nxt_dfa = trap.dfa_ea & SPRB_LO32_MASK;
        end
        // Narrowing the mask also drops bits already held, so reserved
        // bits can never stay visible once they are declared unused
        nxt_sfc = sfc_ff & sfc_impl_mask;
        if (sw_sfc_we)
            nxt_sfc = sw_wdata & sfc_impl_mask;
        if (trap.sfc_load)
            nxt_sfc = trap.sfc_val & sfc_impl_mask;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dfa_ff <= SPRB_RST64;
            sfc_ff <= SPRB_RST32;
        end
        else
        begin
            dfa_ff <= nxt_dfa;
            sfc_ff <= nxt_sfc;
        end
    end

    AST_DFA_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        trap.dfa_load && !trap.mode32 |=> dfa_ff == $past(trap.dfa_ea))
        else $error("fault address not captured");
    AST_DFA_32: assert property (@(posedge pclk) disable iff (!presetn)
        trap.dfa_load && trap.mode32 |=> dfa_ff[63:32] == 32'h0)
        else $error("upper fault address not cleared");
    AST_SFC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        trap.sfc_load |=>
        sfc_ff == ($past(trap.sfc_val) & $past(sfc_impl_mask)))
        else $error("fault cause not captured");
    AST_SFC_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        (sfc_ff & ~$past(sfc_impl_mask)) == 32'h0)
        else $error("reserved cause bit set");
endmodule

//--- sprb_bank.sv
// Supervisor special register bank with APB slave and core-side ports
`timescale 1ns/1ps
// Summary of operation
// - Bit 63 of the address space register may act as origin-valid flag.
// - Valid flag set: origin field is valid, used for 64-bit translation.
// - Flag and 64-bit mode both clear: 16 buffer entries act as segments.
// - While flag is zero, a bad origin address raises no machine check.
// - Bits 0-51 hold segment table address; bits 52-62 are reserved.
// - Flag not implemented: bit 63 reserved, translation acts as if set.
// - On a memory-access exception the effective address is captured.
// - Exception in 32-bit mode clears upper 32 fault address bits.
// - Four 64-bit scratch registers with no hardware meaning.
// - Fourth scratch readable from user mode by option; rest supervisor.
// - Cause register records storage, check, segment, alignment faults.
// - Cause bits never set by any exception may be reserved.
module sprb_bank
    import sprb_pkg::*;
#(
    parameter bit VALID_IMPL = 1'b1,
    parameter bit SCR3_USER_READ = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic sixty_four_bit_mode_flag,
    input wire logic dfa_load,
    input wire logic [63:0] dfa_ea,
    input wire logic sfc_load,
    input wire logic [31:0] sfc_val,
    input wire logic sto_fetch_err,
    output logic [51:0] segment_table_origin,
    output logic sto_valid,
    output logic seg_reg_mode,
    output logic machine_check
);
    logic [63:0] asr_ff;
    logic [63:0] nxt_asr;
    logic [63:0] scr_ff [SPRB_NUM_SCR];
    logic [63:0] nxt_scr [SPRB_NUM_SCR];
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [63:0] dfa_q;
    logic [31:0] sfc_q;
    logic [1:0] dfa_we;
    logic sfc_we;
    logic setup;
    logic supv;
    logic hit;
    logic allowed;
    logic wr_ok;
    logic [31:0] rd_word;
    sprb_apb_t apb_ff;
    sprb_apb_t nxt_apb;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic flag_eff;
    logic nxt_sto_valid;
    logic nxt_seg_mode;
    logic nxt_mc;

    sprb_trap_if trap ();
    assign trap.dfa_load = dfa_load;
    assign trap.dfa_ea = dfa_ea;
    assign trap.mode32 = !sixty_four_bit_mode_flag;
    assign trap.sfc_load = sfc_load;
    assign trap.sfc_val = sfc_val;

    // ****************************************************************
    // Access decode
    // ****************************************************************
    assign setup = psel && !penable && apb_ff == SPRB_IDLE;
    assign supv = pprot[0];

    always_comb
    begin
        hit = 1'b1;
        rd_word = 32'h0;
        case (paddr)
            SPRB_ASR_LO: rd_word = asr_ff[31:0];
            SPRB_ASR_HI: rd_word = asr_ff[63:32];
            SPRB_DFA_LO: rd_word = dfa_q[31:0];
            SPRB_DFA_HI: rd_word = dfa_q[63:32];
            SPRB_SFC: rd_word = sfc_q;
            SPRB_CTRL: rd_word = ctrl_ff;
            SPRB_STAT: rd_word = {29'h0, machine_check, seg_reg_mode,
                sto_valid};
            default:
            begin
                hit = 1'b0;
                for (int i = 0; i < SPRB_NUM_SCR; i++)
                begin
                    if (paddr == SPRB_SCR_BASE + 8'(8 * i))
                    begin
                        hit = 1'b1;
                        rd_word = scr_ff[i][31:0];
                    end
                    if (paddr == SPRB_SCR_BASE + 8'(8 * i + 4))
                    begin
                        hit = 1'b1;
                        rd_word = scr_ff[i][63:32];
                    end
                end
            end
        endcase
        // User mode may only read the fourth scratch, when enabled
        allowed = supv || (SCR3_USER_READ && !pwrite &&
            paddr[7:3] == 5'(({3'h0, SPRB_SCR_BASE[7:3]}) + 8'h3));
        wr_ok = setup && pwrite && hit && allowed;
        if (paddr == SPRB_STAT)
            wr_ok = 1'b0;
    end

    // ****************************************************************
    // APB slave, no wait states: answer in the access phase
    // ****************************************************************
    always_comb
    begin
        nxt_apb = apb_ff;
        nxt_prdata = prdata;
        nxt_pslverr = pslverr;
        case (apb_ff)
            SPRB_IDLE:
                if (setup)
                begin
                    nxt_apb = SPRB_ACC;
                    // Reads only sample state, so they change nothing
                    nxt_prdata = (!pwrite && hit && allowed) ? rd_word
                        : SPRB_ERR_DATA;
                    // The status word is read-only, so a write is refused
                    nxt_pslverr = !(hit && allowed)
                        || (pwrite && paddr == SPRB_STAT);
                end
            SPRB_ACC:
            begin
                nxt_apb = SPRB_IDLE;
                nxt_prdata = SPRB_ERR_DATA;
                nxt_pslverr = 1'b0;
            end
            default: nxt_apb = SPRB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_ff <= SPRB_IDLE;
            pready <= 1'b0;
            prdata <= SPRB_ERR_DATA;
            pslverr <= 1'b0;
        end
        else
        begin
            apb_ff <= nxt_apb;
            pready <= nxt_apb == SPRB_ACC;
            prdata <= nxt_prdata;
            pslverr <= nxt_pslverr;
        end
    end

    // ****************************************************************
    // Register state, written at setup so the answer reflects it
    // ****************************************************************
    always_comb
    begin
        nxt_asr = asr_ff;
        nxt_ctrl = ctrl_ff;
        dfa_we = 2'b00;
        sfc_we = 1'b0;
        if (wr_ok && paddr == SPRB_ASR_LO)
            nxt_asr[31:0] = pwdata;
        if (wr_ok && paddr == SPRB_ASR_HI)
            nxt_asr[63:32] = pwdata;
        // Reserved bits 52-62 hold zero; flag bit kept only if present
        nxt_asr = nxt_asr & SPRB_ASR_MASK;
        if (VALID_IMPL && wr_ok && paddr == SPRB_ASR_LO)
            nxt_asr[SPRB_V_IDX] = pwdata[SPRB_V_IDX];
        else if (VALID_IMPL)
            nxt_asr[SPRB_V_IDX] = asr_ff[SPRB_V_IDX];
        if (wr_ok && paddr == SPRB_CTRL)
            nxt_ctrl = pwdata;
        dfa_we[0] = wr_ok && paddr == SPRB_DFA_LO;
        dfa_we[1] = wr_ok && paddr == SPRB_DFA_HI;
        sfc_we = wr_ok && paddr == SPRB_SFC;
        for (int i = 0; i < SPRB_NUM_SCR; i++)
        begin
            nxt_scr[i] = scr_ff[i];
            // Plain storage, no hardware meaning attached
            if (wr_ok && paddr == SPRB_SCR_BASE + 8'(8 * i))
                nxt_scr[i][31:0] = pwdata;
            if (wr_ok && paddr == SPRB_SCR_BASE + 8'(8 * i + 4))
                nxt_scr[i][63:32] = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            asr_ff <= SPRB_RST64;
            ctrl_ff <= SPRB_SFC_IMPL;
        end
        else
        begin
            asr_ff <= nxt_asr;
            ctrl_ff <= nxt_ctrl;
        end
    end

    generate
        for (genvar g = 0; g < SPRB_NUM_SCR; g++)
        begin : g_scr
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    scr_ff[g] <= SPRB_RST64;
                else
                    scr_ff[g] <= nxt_scr[g];
            end
        end
    endgenerate

    sprb_fault_capture u_fault (
        .pclk(pclk),
        .presetn(presetn),
        .trap(trap),
        .sfc_impl_mask(ctrl_ff),
        .sw_dfa_we(dfa_we),
        .sw_sfc_we(sfc_we),
        .sw_wdata(pwdata),
        .dfa_ff(dfa_q),
        .sfc_ff(sfc_q)
    );

    // ****************************************************************
    // Translation controls toward the core
    // ****************************************************************
    always_comb
    begin
        // Without the flag, translation behaves as if it were set
        flag_eff = VALID_IMPL ? asr_ff[SPRB_V_IDX] : 1'b1;
        nxt_sto_valid = flag_eff;
        nxt_seg_mode = !flag_eff && !sixty_four_bit_mode_flag;
        // A bad origin only matters when the origin is in use
        nxt_mc = sto_fetch_err && flag_eff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            segment_table_origin <= 52'h0;
            sto_valid <= 1'b0;
            seg_reg_mode <= 1'b0;
            machine_check <= 1'b0;
        end
        else
        begin
            segment_table_origin <= asr_ff[63:12];
            sto_valid <= nxt_sto_valid;
            seg_reg_mode <= nxt_seg_mode;
            machine_check <= nxt_mc;
        end
    end

    AST_NO_MC: assert property (@(posedge pclk) disable iff (!presetn)
        !asr_ff[SPRB_V_IDX] && VALID_IMPL |=> !machine_check)
        else $error("machine check with origin invalid");
    AST_SEG_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        VALID_IMPL && !asr_ff[SPRB_V_IDX] && !sixty_four_bit_mode_flag
        |=> seg_reg_mode)
        else $error("segment register mode missing");
    AST_VALID: assert property (@(posedge pclk) disable iff (!presetn)
        asr_ff[SPRB_V_IDX] |=> sto_valid)
        else $error("origin valid not shown");
    AST_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        asr_ff[11:1] == 11'h0)
        else $error("reserved address space bits set");
    AST_NOIMPL: assert property (@(posedge pclk) disable iff (!presetn)
        !VALID_IMPL |-> asr_ff[SPRB_V_IDX] == 1'b0 ##1 sto_valid)
        else $error("flag absent but translation off");
    AST_FLAG_WR: assert property (@(posedge pclk) disable iff (!presetn)
        VALID_IMPL && wr_ok && paddr == SPRB_ASR_LO
        |=> asr_ff[SPRB_V_IDX] == $past(pwdata[SPRB_V_IDX]))
        else $error("valid flag not stored");
    AST_SCR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok && paddr == SPRB_SCR_BASE |=> scr_ff[0][31:0] == $past(pwdata))
        else $error("scratch write lost");
    AST_USER: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !supv && (pwrite || paddr[7:3] != 5'h5) |=> pslverr && pready)
        else $error("user access not refused");
    AST_APB: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
endmodule

//--- sprb_core_model.sv
// Behavioural model of the core side that drives the load, mode and fetch error inputs of the bank
`timescale 1ns/1ps
module sprb_core_model
(
    input wire logic pclk,
    output logic sixty_four_bit_mode_flag,
    output logic dfa_load,
    output logic [63:0] dfa_ea,
    output logic sfc_load,
    output logic [31:0] sfc_val,
    output logic sto_fetch_err
);
    initial
    begin
        sixty_four_bit_mode_flag = 1'b1;
        dfa_load = 1'b0;
        dfa_ea = 64'h0;
        sfc_load = 1'b0;
        sfc_val = 32'h0;
        sto_fetch_err = 1'b0;
    end

    // ****************************************************************
    // One-cycle load pulses; data is scrambled once the pulse is over
    // ****************************************************************
    task automatic set_mode(input logic m);
        @(posedge pclk);
        sixty_four_bit_mode_flag <= m;
    endtask

    task automatic pulse(input logic d, input logic s, input logic f,
        input logic [63:0] ea, input logic [31:0] v);
        @(posedge pclk);
        dfa_load <= d;
        dfa_ea <= ea;
        sfc_load <= s;
        sfc_val <= v;
        sto_fetch_err <= f;
        @(posedge pclk);
        dfa_load <= 1'b0;
        sfc_load <= 1'b0;
        sto_fetch_err <= 1'b0;
        dfa_ea <= ~ea;
        sfc_val <= ~v;
    endtask

    task automatic dfa(input logic [63:0] ea);
        pulse(1'b1, 1'b0, 1'b0, ea, 32'h0);
    endtask

    task automatic sfc(input logic [31:0] v);
        pulse(1'b0, 1'b1, 1'b0, 64'h0, v);
    endtask

    task automatic fetch_err();
        pulse(1'b0, 1'b0, 1'b1, 64'h0, 32'h0);
    endtask
endmodule

//--- tb.sv
// Self-checking testbench for the supervisor register bank
`timescale 1ns/1ps
module tb;
    import sprb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] pprot;
    logic pready, pslverr, mode, dl, sl, fe, sv, srm, mc;
    logic [63:0] ea;
    logic [31:0] sval;
    logic [51:0] sto;
    int err_count = 0;
    int check_count = 0;
    int mc_count = 0;

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    sprb_core_model core (.pclk(pclk), .sixty_four_bit_mode_flag(mode),
        .dfa_load(dl), .dfa_ea(ea), .sfc_load(sl), .sfc_val(sval),
        .sto_fetch_err(fe));

    sprb_bank #(.VALID_IMPL(1'b1), .SCR3_USER_READ(1'b1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sixty_four_bit_mode_flag(mode), .dfa_load(dl), .dfa_ea(ea),
        .sfc_load(sl), .sfc_val(sval), .sto_fetch_err(fe),
        .segment_table_origin(sto), .sto_valid(sv), .seg_reg_mode(srm),
        .machine_check(mc));

    always @(posedge pclk)
        if (mc === 1'b1)
            mc_count <= mc_count + 1;

    // ****************************************************************
    // Reporting and APB master
    // ****************************************************************
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] s, e);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Idle cycle first, so a strobe is never assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [2:0] p,
        output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 3'h1, r, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [2:0] p, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, p, r, e);
        chk(nm, {32'h0, r}, {32'h0, x});
        chk({nm, "_err"}, {63'h0, e}, {63'h0, xe});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rdc("asr_lo", SPRB_ASR_LO, 3'h1, 32'h0, 1'b0);
        rdc("dfa_hi", SPRB_DFA_HI, 3'h1, 32'h0, 1'b0);
        rdc("ctrl", SPRB_CTRL, 3'h1, SPRB_SFC_IMPL, 1'b0);
        rdc("stat", SPRB_STAT, 3'h1, 32'h0, 1'b0);
        $display("reset values done");
    endtask

    task automatic t_asr();
        wr(SPRB_ASR_HI, 32'h1234_5678);
        wr(SPRB_ASR_LO, 32'hffff_ffff);
        rdc("asr_lo", SPRB_ASR_LO, 3'h1, 32'hffff_f001, 1'b0);
        chk("origin", {12'h0, sto}, 64'h1234_5678_ffff_f);
        chk("sto_valid", {63'h0, sv}, 64'h1);
        wr(SPRB_ASR_LO, 32'habcd_e000);
        core.set_mode(1'b0);
        repeat (2) @(posedge pclk);
        chk("sto_valid", {63'h0, sv}, 64'h0);
        chk("seg_mode", {63'h0, srm}, 64'h1);
        rdc("stat", SPRB_STAT, 3'h1, 32'h2, 1'b0);
        core.set_mode(1'b1);
        repeat (2) @(posedge pclk);
        chk("seg_mode", {63'h0, srm}, 64'h0);
        $display("address space done");
    endtask

    task automatic t_mc();
        int b;
        b = mc_count;
        core.fetch_err();
        repeat (3) @(posedge pclk);
        chk("mc_off", 64'(mc_count - b), 64'h0);
        wr(SPRB_ASR_LO, 32'habcd_e001);
        core.fetch_err();
        repeat (3) @(posedge pclk);
        chk("mc_on", 64'(mc_count - b), 64'h1);
        $display("machine check done");
    endtask

    task automatic t_dfa();
        core.dfa(64'h0123_4567_89ab_cdef);
        rdc("dfa_hi", SPRB_DFA_HI, 3'h1, 32'h0123_4567, 1'b0);
        rdc("dfa_lo", SPRB_DFA_LO, 3'h1, 32'h89ab_cdef, 1'b0);
        core.set_mode(1'b0);
        core.dfa(64'hfedc_ba98_7654_3210);
        core.set_mode(1'b1);
        rdc("dfa_hi", SPRB_DFA_HI, 3'h1, 32'h0, 1'b0);
        rdc("dfa_lo", SPRB_DFA_LO, 3'h1, 32'h7654_3210, 1'b0);
        rdc("dfa_lo", SPRB_DFA_LO, 3'h1, 32'h7654_3210, 1'b0);
        $display("fault address done");
    endtask

    task automatic t_scr();
        logic [7:0] a;
        for (int i = 0; i < SPRB_NUM_SCR; i++)
        begin
            a = SPRB_SCR_BASE + 8'(8 * i);
            wr(a, 32'h5a00_0000 + 32'(i));
            wr(a + 8'h4, 32'ha500_0000 + 32'(i));
        end
        for (int i = 0; i < SPRB_NUM_SCR; i++)
        begin
            a = SPRB_SCR_BASE + 8'(8 * i);
            rdc("scr_lo", a, 3'h1, 32'h5a00_0000 + 32'(i), 1'b0);
            rdc("scr_hi", a + 8'h4, 3'h1, 32'ha500_0000 + 32'(i), 1'b0);
        end
        rdc("scr3_user", 8'h28, 3'h0, 32'h5a00_0003, 1'b0);
        rdc("scr0_user", 8'h10, 3'h0, 32'h0, 1'b1);
        rdc("scr3_user", 8'h2c, 3'h0, 32'ha500_0003, 1'b0);
        $display("scratch done");
    endtask

    task automatic t_sfc();
        logic [31:0] r;
        logic e;
        core.sfc(32'hdead_beef);
        rdc("sfc", SPRB_SFC, 3'h1, 32'hdead_beef, 1'b0);
        wr(SPRB_CTRL, 32'h0000_ffff);
        core.sfc(32'h1234_5678);
        rdc("sfc", SPRB_SFC, 3'h1, 32'h0000_5678, 1'b0);
        apb(1'b1, 8'h28, 32'h0, 3'h0, r, e);
        chk("user_wr_err", {63'h0, e}, 64'h1);
        rdc("scr3", 8'h28, 3'h1, 32'h5a00_0003, 1'b0);
        apb(1'b1, SPRB_STAT, 32'hffff_ffff, 3'h1, r, e);
        chk("stat_wr_err", {63'h0, e}, 64'h1);
        rdc("unmapped", 8'h3c, 3'h1, 32'h0, 1'b1);
        $display("cause and refusals done");
    endtask

    // Reset again in mid-run: address space, control, scratch 3 and the machine check, origin and valid outputs must return to their start
    task automatic t_rst2();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("mc_rst", {63'h0, mc}, 64'h0);
        chk("origin_rst", {12'h0, sto}, 64'h0);
        presetn <= 1'b1;
        rdc("asr_lo", SPRB_ASR_LO, 3'h1, 32'h0, 1'b0);
        rdc("ctrl", SPRB_CTRL, 3'h1, SPRB_SFC_IMPL, 1'b0);
        rdc("scr3_hi", 8'h2c, 3'h1, 32'h0, 1'b0);
        chk("sto_valid", {63'h0, sv}, 64'h0);
        $display("second reset done");
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pprot = 3'h1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_asr();
        t_mc();
        t_dfa();
        t_scr();
        t_sfc();
        t_rst2();
        wrap_up();
    end
endmodule
